// *** rtl/dbgmb_pkg.sv ***
// Package for the debug mailbox: register offsets, field positions, reset values.
// Assumes a 32-bit Avalon-MM software bus and a word-wide debug access port.
package dbgmb_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 16;
  localparam int NUM_IRQ = 4;
  // Software-visible offsets.
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 16'h1030;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 16'h1028;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASKED = 16'h1038;
  localparam logic [ADDR_W-1:0] OFS_IRQ_SET = 16'h1040;
  localparam logic [ADDR_W-1:0] OFS_INTERRUPT_CLEAR = 16'h1048;
  localparam logic [ADDR_W-1:0] OFS_EVENT_LINE_MODE = 16'h10e0;
  localparam logic [ADDR_W-1:0] OFS_MODULE_DESCRIPTOR = 16'h10fc;
  localparam logic [ADDR_W-1:0] OFS_INBOUND_WORD = 16'h1100;
  localparam logic [ADDR_W-1:0] OFS_INBOUND_CONTROL = 16'h1104;
  localparam logic [ADDR_W-1:0] OFS_OUTBOUND_WORD = 16'h1108;
  localparam logic [ADDR_W-1:0] OFS_OUTBOUND_CONTROL = 16'h110c;
  // Interrupt bit positions.
  localparam int BIT_POWER_DOWN = 3;
  localparam int BIT_POWER_UP = 2;
  localparam int BIT_OUTBOUND_WORD = 1;
  localparam int BIT_INBOUND_WORD = 0;
  // Event line mode encodings.
  localparam logic [1:0] MODE_DISABLED = 2'h0;
  localparam logic [1:0] MODE_SOFTWARE = 2'h1;
  localparam logic [1:0] MODE_HARDWARE = 2'h2;
  localparam logic [1:0] LINE_MODE_RESET = MODE_SOFTWARE;
  // Descriptor field values; the module code is arbitrary.
  localparam logic [15:0] MODULE_CODE = 16'h5a5a;
  localparam logic [3:0] FEATURE_SET = 4'h0;
  localparam logic [3:0] MAJOR_REVISION = 4'h0;
  localparam logic [3:0] MINOR_REVISION = 4'h0;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [NUM_IRQ-1:0] ZERO_IRQ = 4'h0;
  // Control word fields: the full flag and the software outbound flags.
  localparam int FULL_BIT = 0;
  localparam int OUT_FLAG_MSB = 7;
  localparam int OUT_FLAG_LSB = 1;
  // Tool port address decode: word select.
  typedef enum logic [1:0] {
    DBGMB_PORT_WORD = 2'b00,
    DBGMB_PORT_CONTROL = 2'b01,
    DBGMB_PORT_OUTBOUND = 2'b10,
    DBGMB_PORT_OUT_CONTROL = 2'b11
  } dbgmb_port_sel_t;
endpackage : dbgmb_pkg

// *** rtl/dbgmb_if.sv ***
// Interface joining the mailbox device to the debug tool end.
// Simple one-cycle strobed access port; reads answer in the next cycle.
`timescale 1ns/1ps
`default_nettype none
interface dbgmb_if;
  import dbgmb_pkg::*;
  logic wr;
  logic rd;
  dbgmb_port_sel_t sel;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic rvalid;
  modport device (input wr, input rd, input sel, input wdata, output rdata, output rvalid);
  modport tool (output wr, output rd, output sel, output wdata, input rdata, input rvalid);
endinterface : dbgmb_if
`default_nettype wire

// *** rtl/dbgmb_flag.sv ***
// One sticky flag with set-over-clear priority.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module dbgmb_flag (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Controls.
  input wire logic set_i,
  input wire logic clear_i,
  // State.
  output logic flag_o
);
  // A set in the same cycle as a clear wins so no event is lost.
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      flag_o <= 1'b0;
    else if (set_i)
      flag_o <= 1'b1;
    else if (clear_i)
      flag_o <= 1'b0;
  end
endmodule // dbgmb_flag
`default_nettype wire

// *** rtl/dbgmb_tool.sv ***
// Debug tool end: takes user commands and drives the access port.
// Assumes user requests are held until done_o pulses.
`timescale 1ns/1ps
`default_nettype none
module dbgmb_tool (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic reset_n_i,
  // User side.
  input wire logic req_i,
  input wire logic req_write_i,
  input wire dbgmb_pkg::dbgmb_port_sel_t req_sel_i,
  input wire logic [dbgmb_pkg::DATA_W-1:0] req_wdata_i,
  output logic done_o,
  output logic [dbgmb_pkg::DATA_W-1:0] rdata_o,
  // Access port.
  dbgmb_if.tool port
);
  import dbgmb_pkg::*;
  typedef enum logic [1:0] {
    DBGMB_T_IDLE = 2'b00,
    DBGMB_T_POLL = 2'b01,
    DBGMB_T_WAIT = 2'b10,
    DBGMB_T_DONE = 2'b11
  } dbgmb_tstate_t;
  dbgmb_tstate_t state;
  // A word write first polls the inbound-full flag until it reads empty.
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state <= DBGMB_T_IDLE;
      port.wr <= 1'b0;
      port.rd <= 1'b0;
      port.sel <= DBGMB_PORT_WORD;
      port.wdata <= ZERO_WORD;
      done_o <= 1'b0;
      rdata_o <= ZERO_WORD;
    end
    else
    begin
      port.wr <= 1'b0;
      port.rd <= 1'b0;
      done_o <= 1'b0;
      case (state)
        DBGMB_T_IDLE:
          if (req_i && !done_o)
          begin
            if (req_write_i && req_sel_i == DBGMB_PORT_WORD)
            begin
              port.rd <= 1'b1;
              port.sel <= DBGMB_PORT_CONTROL;
              state <= DBGMB_T_POLL;
            end
            else
            begin
              port.wr <= req_write_i;
              port.rd <= !req_write_i;
              port.sel <= req_sel_i;
              port.wdata <= req_wdata_i;
              state <= req_write_i ? DBGMB_T_DONE : DBGMB_T_WAIT;
            end
          end
        DBGMB_T_POLL:
          if (port.rvalid)
          begin
            if (port.rdata[FULL_BIT])
            begin
              port.rd <= 1'b1;
            end
            else
            begin
              port.wr <= 1'b1;
              port.sel <= DBGMB_PORT_WORD;
              port.wdata <= req_wdata_i;
              state <= DBGMB_T_DONE;
            end
          end
        DBGMB_T_WAIT:
          if (port.rvalid)
          begin
            rdata_o <= port.rdata;
            done_o <= 1'b1;
            state <= DBGMB_T_IDLE;
          end
        DBGMB_T_DONE:
        begin
          done_o <= 1'b1;
          state <= DBGMB_T_IDLE;
        end
        default:
          state <= DBGMB_T_IDLE;
      endcase
    end
  end
endmodule // dbgmb_tool
`default_nettype wire

// *** rtl/dbgmb_device.sv ***
// Debug mailbox device: Avalon-MM register slave plus the tool access port.
// Assumes one clock; the tool port and event inputs are on that clock.
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Clear register ones clear raw status bits.
// - Interrupt bits: power-down 3, power-up 2, words 1/0.
// - Line mode field reads constant, resets software.
// - Software mode: flag held until software clears.
// - Hardware mode: consumer clears flag automatically.
// - Descriptor upper half holds module code.
// - Descriptor lower fields: feature, instance, revisions.
// - Tool writes inbound word, processor reads.
// - Tool write sets inbound-full flag.
// - Processor inbound read clears inbound-full.
// - Tool polls inbound-full before writing.
// - Inbound control upper bits are tool flags.
// - Processor writes outbound word, tool reads.
// - Outbound-full set by write, cleared by tool read.
// - Masked status equals mask AND raw.
// - Set register ones set raw status bits.
// - Clear works even when mask disabled.
module dbgmb_device #(
  parameter logic [3:0] INSTANCE_INDEX = 4'h0
) (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Avalon-MM slave.
  input wire logic [dbgmb_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [dbgmb_pkg::DATA_W-1:0] avs_writedata_i,
  output logic [dbgmb_pkg::DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Power events and hardware consumer acknowledge.
  input wire logic power_down_event_i,
  input wire logic power_up_event_i,
  input wire logic [dbgmb_pkg::NUM_IRQ-1:0] consumer_ack_i,
  // Interrupt.
  output logic irq_o,
  // Tool access port.
  dbgmb_if.device port
);
  import dbgmb_pkg::*;
  localparam logic [1:0] LINE_MODE = LINE_MODE_RESET;
  logic [DATA_W-1:0] inbound_word;
  logic [DATA_W-1:1] inbound_flags;
  logic [DATA_W-1:0] outbound_word;
  logic [OUT_FLAG_MSB:OUT_FLAG_LSB] outbound_flags;
  logic [NUM_IRQ-1:0] interrupt_mask;
  logic [NUM_IRQ-1:0] raw_status;
  logic [NUM_IRQ-1:0] masked_status;
  logic [NUM_IRQ-1:0] event_set;
  logic [NUM_IRQ-1:0] event_clear;
  logic inbound_full;
  logic outbound_full;
  logic access;
  logic sw_wr;
  logic sw_rd;
  logic tool_in_wr;
  logic tool_out_rd;

  // Each access takes one wait cycle so reads come from registered data.
  assign access = (avs_read_i || avs_write_i) && avs_waitrequest_o;
  assign sw_wr = avs_write_i && !avs_waitrequest_o;
  assign sw_rd = avs_read_i && !avs_waitrequest_o;
  assign tool_in_wr = port.wr && port.sel == DBGMB_PORT_WORD;
  assign tool_out_rd = port.rd && port.sel == DBGMB_PORT_OUTBOUND;

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      avs_waitrequest_o <= 1'b1;
    else
      avs_waitrequest_o <= !access;
  end

  // Event sources; a disabled line ignores hardware events, not software sets.
  always_comb
  begin
    event_set = ZERO_IRQ;
    event_clear = ZERO_IRQ;
    if (LINE_MODE != MODE_DISABLED)
    begin
      event_set[BIT_POWER_DOWN] = power_down_event_i;
      event_set[BIT_POWER_UP] = power_up_event_i;
      event_set[BIT_OUTBOUND_WORD] = sw_wr && avs_address_i == OFS_OUTBOUND_WORD;
      event_set[BIT_INBOUND_WORD] = tool_in_wr;
    end
    if (sw_wr && avs_address_i == OFS_IRQ_SET)
      event_set = event_set | avs_writedata_i[NUM_IRQ-1:0];
    if (sw_wr && avs_address_i == OFS_INTERRUPT_CLEAR)
      event_clear = avs_writedata_i[NUM_IRQ-1:0];
    if (LINE_MODE == MODE_HARDWARE)
      event_clear = event_clear | consumer_ack_i;
  end

  // One sticky raw flag per source; software mode holds it until a clear.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IRQ; gi = gi + 1)
    begin : g_raw
      dbgmb_flag u_flag (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .set_i(event_set[gi]),
        .clear_i(event_clear[gi]),
        .flag_o(raw_status[gi])
      );
    end
  endgenerate

  assign masked_status = raw_status & interrupt_mask;

  // Interrupt line is registered, high while any enabled raw bit is set.
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      irq_o <= 1'b0;
    else
      irq_o <= |masked_status;
  end

  // Software-written configuration and outbound data.
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      interrupt_mask <= ZERO_IRQ;
      outbound_word <= ZERO_WORD;
      outbound_flags <= 7'h00;
    end
    else if (sw_wr)
    begin
      if (avs_address_i == OFS_IRQ_MASK)
        interrupt_mask <= avs_writedata_i[NUM_IRQ-1:0];
      if (avs_address_i == OFS_OUTBOUND_WORD)
        outbound_word <= avs_writedata_i;
      if (avs_address_i == OFS_OUTBOUND_CONTROL)
        outbound_flags <= avs_writedata_i[OUT_FLAG_MSB:OUT_FLAG_LSB];
    end
  end

  // Tool-written inbound data and general flags.
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      inbound_word <= ZERO_WORD;
      inbound_flags <= 31'h0000_0000;
    end
    else
    begin
      if (tool_in_wr)
        inbound_word <= port.wdata;
      if (port.wr && port.sel == DBGMB_PORT_CONTROL)
        inbound_flags <= port.wdata[DATA_W-1:1];
    end
  end

  // Full flags: the writer's set wins over a same-cycle read.
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      inbound_full <= 1'b0;
      outbound_full <= 1'b0;
    end
    else
    begin
      if (tool_in_wr)
        inbound_full <= 1'b1;
      else if (sw_rd && avs_address_i == OFS_INBOUND_WORD)
        inbound_full <= 1'b0;
      if (sw_wr && avs_address_i == OFS_OUTBOUND_WORD)
        outbound_full <= 1'b1;
      else if (tool_out_rd)
        outbound_full <= 1'b0;
    end
  end

  // Software read mux; unmapped and write-only offsets read zero.
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      avs_readdata_o <= ZERO_WORD;
    else if (access && avs_read_i)
    begin
      case (avs_address_i)
        OFS_IRQ_STATUS: avs_readdata_o <= {28'h0000000, raw_status};
        OFS_IRQ_MASK: avs_readdata_o <= {28'h0000000, interrupt_mask};
        OFS_IRQ_MASKED: avs_readdata_o <= {28'h0000000, masked_status};
        OFS_EVENT_LINE_MODE: avs_readdata_o <= {30'h00000000, LINE_MODE};
        OFS_MODULE_DESCRIPTOR: avs_readdata_o <= {MODULE_CODE, FEATURE_SET,
          INSTANCE_INDEX, MAJOR_REVISION, MINOR_REVISION};
        OFS_INBOUND_WORD: avs_readdata_o <= inbound_word;
        OFS_INBOUND_CONTROL: avs_readdata_o <= {inbound_flags, inbound_full};
        OFS_OUTBOUND_WORD: avs_readdata_o <= outbound_word;
        OFS_OUTBOUND_CONTROL: avs_readdata_o <= {24'h000000, outbound_flags, outbound_full};
        default: avs_readdata_o <= ZERO_WORD;
      endcase
    end
  end

  // Tool read answer, one cycle after the strobe.
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      port.rdata <= ZERO_WORD;
      port.rvalid <= 1'b0;
    end
    else
    begin
      port.rvalid <= port.rd;
      if (port.rd)
      begin
        case (port.sel)
          DBGMB_PORT_WORD: port.rdata <= inbound_word;
          DBGMB_PORT_CONTROL: port.rdata <= {inbound_flags, inbound_full};
          DBGMB_PORT_OUTBOUND: port.rdata <= outbound_word;
          DBGMB_PORT_OUT_CONTROL: port.rdata <= {24'h000000, outbound_flags, outbound_full};
          default: port.rdata <= ZERO_WORD;
        endcase
      end
    end
  end
endmodule // dbgmb_device
`default_nettype wire

// *** sim/dbgmb_asserts.sv ***
// Checker for the mailbox: tool port timing and software bus answers.
// Instantiated by the bench beside the interface; it watches signals only.
`timescale 1ns/1ps
`default_nettype none
module dbgmb_asserts #(
  parameter logic [3:0] INSTANCE_INDEX = 4'h0
) (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Tool port.
  input wire logic wr,
  input wire logic rd,
  input wire dbgmb_pkg::dbgmb_port_sel_t sel,
  input wire logic [dbgmb_pkg::DATA_W-1:0] wdata,
  input wire logic [dbgmb_pkg::DATA_W-1:0] rdata,
  input wire logic rvalid,
  // Software bus.
  input wire logic [dbgmb_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [dbgmb_pkg::DATA_W-1:0] avs_readdata_o,
  input wire logic avs_waitrequest_o
);
  import dbgmb_pkg::*;
  dbgmb_port_sel_t last_sel;
  logic ctl_empty;
  logic sw_ans;
  // Remember which word a tool read asked for, so its answer can be judged.
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i) last_sel <= DBGMB_PORT_WORD;
    else if (rd) last_sel <= sel;
  end
  // Last polled inbound-full state; a write consumes it, so every word needs a fresh poll.
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i) ctl_empty <= 1'b0;
    else if (wr && sel == DBGMB_PORT_WORD) ctl_empty <= 1'b0;
    else if (rvalid && last_sel == DBGMB_PORT_CONTROL) ctl_empty <= !rdata[0];
  end
  // A software read is answered in the cycle where waitrequest is low.
  assign sw_ans = avs_read_i && !avs_waitrequest_o;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);
  a_rvalid_follows_rd: assert property (rd |=> rvalid)
    else $error("tool read got no answer");
  a_rvalid_has_cause: assert property (rvalid |-> $past(rd))
    else $error("tool answer without read");
  a_tool_polls_empty: assert property (wr && sel == DBGMB_PORT_WORD |->
    ctl_empty || (rvalid && last_sel == DBGMB_PORT_CONTROL && !rdata[0]))
    else $error("tool wrote word without seeing empty");
  a_one_wait_state: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o)
    else $error("bus answer not one cycle later");
  a_wait_low_once: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  a_mode_reads_const: assert property (sw_ans && avs_address_i == OFS_EVENT_LINE_MODE
    |-> avs_readdata_o == {30'h0, LINE_MODE_RESET})
    else $error("line mode read not constant");
  a_module_descriptor_fields: assert property (sw_ans && avs_address_i == OFS_MODULE_DESCRIPTOR
    |-> avs_readdata_o == {MODULE_CODE, FEATURE_SET, INSTANCE_INDEX, MAJOR_REVISION,
    MINOR_REVISION})
    else $error("descriptor read wrong");
  a_unmapped_zero: assert property (sw_ans && avs_address_i[15:12] != 4'h1
    |-> avs_readdata_o == ZERO_WORD)
    else $error("unmapped read not zero");
endmodule // dbgmb_asserts
`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench: device and tool end joined through the port interface.
// Assumes the hand-over timing: one wait state on the bus, done pulse on the tool side.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dbgmb_pkg::*;
  logic clock_i, reset_n_i, rd, wr, pdn, pup, irq, wt, req, req_w, done;
  logic [15:0] addr;
  logic [31:0] wdat, rdat, rwd, trd, q, d;
  logic [3:0] ack;
  dbgmb_port_sel_t rsel;
  int err_count, n_compared, cycles, raw, mask, ctl, s, c;
  int inq[$];
  dbgmb_if port_if();
  dbgmb_device #(.INSTANCE_INDEX(4'h3)) dbgmb_device_i (.clock_i(clock_i),
    .reset_n_i(reset_n_i), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_readdata_o(rdat), .avs_waitrequest_o(wt),
    .power_down_event_i(pdn), .power_up_event_i(pup), .consumer_ack_i(ack),
    .irq_o(irq), .port(port_if.device));
  dbgmb_tool dbgmb_tool_i (.clock_i(clock_i), .reset_n_i(reset_n_i), .req_i(req),
    .req_write_i(req_w), .req_sel_i(rsel), .req_wdata_i(rwd), .done_o(done),
    .rdata_o(trd), .port(port_if.tool));
  dbgmb_asserts #(.INSTANCE_INDEX(4'h3)) dbgmb_asserts_i (.clock_i(clock_i),
    .reset_n_i(reset_n_i), .wr(port_if.wr), .rd(port_if.rd), .sel(port_if.sel),
    .wdata(port_if.wdata), .rdata(port_if.rdata), .rvalid(port_if.rvalid),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wt));
  // A 100 ns clock.
  initial
  begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // A hang is cut short well past the few hundred cycles the sequence needs.
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One bus access; the request stands until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] v);
    @(posedge clock_i);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdat <= v;
    do @(posedge clock_i); while (wt !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [15:0] a, input int exp);
    bus(1'b0, a, 32'h0);
    chk(q, 32'(exp));
  endtask
  // One tool command; the request stands until done is sampled high.
  task automatic tool(input logic w, input dbgmb_port_sel_t sl, input logic [31:0] v);
    @(posedge clock_i);
    req <= 1'b1;
    req_w <= w;
    rsel <= sl;
    rwd <= v;
    do @(posedge clock_i); while (done !== 1'b1);
    q = trd;
    req <= 1'b0;
  endtask
  // Main sequence; the model keeps raw status, mask, tool flags and inbound words.
  initial
  begin
    {rd, wr, pdn, pup, req, req_w, ack, addr, wdat, rwd} = '0;
    rsel = DBGMB_PORT_WORD;
    reset_n_i = 1'b0;
    void'($urandom(93876));
    repeat (3) @(posedge clock_i);
    reset_n_i <= 1'b1;
    rchk(OFS_EVENT_LINE_MODE, 1);
    rchk(OFS_MODULE_DESCRIPTOR, {MODULE_CODE, 16'h0300});
    bus(1'b1, 16'h2000, 32'hffff_ffff);
    rchk(16'h2000, 0);
    rchk(OFS_INBOUND_WORD, 0);
    for (int i = 0; i < 4; i++)
    begin
      d = $urandom;
      inq.push_back(d);
      tool(1'b1, DBGMB_PORT_WORD, d);
      raw |= 1;
      rchk(OFS_INBOUND_CONTROL, ctl | 1);
      rchk(OFS_INBOUND_WORD, inq.pop_front());
      rchk(OFS_INBOUND_CONTROL, ctl);
      d = $urandom;
      bus(1'b1, OFS_OUTBOUND_WORD, d);
      raw |= 2;
      tool(1'b0, DBGMB_PORT_OUT_CONTROL, 32'h0);
      chk(q, 32'h1);
      tool(1'b0, DBGMB_PORT_OUTBOUND, 32'h0);
      chk(q, d);
      tool(1'b0, DBGMB_PORT_OUT_CONTROL, 32'h0);
      chk(q, 32'h0);
      rchk(OFS_OUTBOUND_WORD, d);
      ctl = $urandom & 32'hffff_fffe;
      tool(1'b1, DBGMB_PORT_CONTROL, 32'(ctl) | 32'h1);
      rchk(OFS_INBOUND_CONTROL, ctl);
    end
    // A second word must keep polling until software has emptied the first.
    d = $urandom;
    inq.push_back(d);
    tool(1'b1, DBGMB_PORT_WORD, d);
    d = $urandom;
    inq.push_back(d);
    fork
      tool(1'b1, DBGMB_PORT_WORD, d);
      begin
        repeat (20) @(posedge clock_i);
        rchk(OFS_INBOUND_WORD, inq.pop_front());
      end
    join
    rchk(OFS_INBOUND_WORD, inq.pop_front());
    // Software flags of the outbound control word reach the tool; bit 0 stays read-only.
    bus(1'b1, OFS_OUTBOUND_CONTROL, 32'hffff_ffff);
    rchk(OFS_OUTBOUND_CONTROL, 32'hfe);
    tool(1'b0, DBGMB_PORT_OUT_CONTROL, 32'h0);
    chk(q, 32'h0000_00fe);
    rchk(OFS_IRQ_STATUS, raw);
    // Consumer acknowledges must not clear flags in software mode.
    repeat (8) @(posedge clock_i) ack <= 4'($urandom);
    @(posedge clock_i) ack <= 4'h0;
    rchk(OFS_IRQ_STATUS, raw);
    @(posedge clock_i) pdn <= 1'b1;
    @(posedge clock_i) pdn <= 1'b0;
    @(posedge clock_i) pup <= 1'b1;
    @(posedge clock_i) pup <= 1'b0;
    raw |= 12;
    rchk(OFS_IRQ_STATUS, raw);
    mask = 5;
    bus(1'b1, OFS_IRQ_MASK, 32'(mask));
    rchk(OFS_IRQ_MASKED, raw & mask);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, OFS_INTERRUPT_CLEAR, 32'ha);
    raw &= ~10;
    rchk(OFS_IRQ_STATUS, raw);
    bus(1'b1, OFS_INTERRUPT_CLEAR, 32'h0);
    rchk(OFS_IRQ_STATUS, raw);
    // An event held across a clear of the same bit must survive it.
    @(posedge clock_i) pdn <= 1'b1;
    bus(1'b1, OFS_INTERRUPT_CLEAR, 32'h8);
    pdn <= 1'b0;
    raw |= 8;
    rchk(OFS_IRQ_STATUS, raw);
    for (int i = 0; i < 8; i++)
    begin
      s = $urandom;
      c = $urandom;
      bus(1'b1, OFS_IRQ_SET, 32'(s));
      raw |= s & 15;
      bus(1'b1, OFS_INTERRUPT_CLEAR, 32'(c));
      raw &= ~c & 15;
      rchk(OFS_IRQ_STATUS, raw);
      rchk(OFS_IRQ_MASKED, raw & mask);
      chk({31'h0, irq}, 32'((raw & mask) != 0));
    end
    // A reset in mid-run empties status and mailbox and restores the line mode.
    @(posedge clock_i) reset_n_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    reset_n_i <= 1'b1;
    rchk(OFS_EVENT_LINE_MODE, 1);
    rchk(OFS_IRQ_STATUS, 0);
    rchk(OFS_INBOUND_CONTROL, 0);
    chk({31'h0, irq}, 32'h0);
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
